//--- digc_capture.sv
// pad input capture: bypass, delay, sdr, ddr and gearbox capture into the system clock
`include "digc_defs.svh"
module digc_capture
  import digc_pkg::*;
#(
  parameter bit SIDE_LR = 1'b1
)(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  input  wire logic        PAD_INPUT_DATA,
  input  wire logic        SHIFTED_STROBE_CLOCK,
  input  wire logic        EDGE_CLOCK,
  input  wire logic        SYNC_CLOCK_POLARITY,
  input  wire logic        SYNC_TRANSFER_LATCH,
  input  wire logic [3:0]  DYNAMIC_DELAY_SELECT,
  input  wire logic        OUT_READY,
  output logic             BYPASS_COMB_INPUT,
  output logic             BYPASS_CLOCK_INPUT,
  output logic             OUT_VALID,
  output logic             GEARBOX_POS_STREAM_A,
  output logic             GEARBOX_NEG_STREAM_A,
  output logic             GEARBOX_POS_STREAM_B,
  output logic             GEARBOX_NEG_STREAM_B
);
  typedef struct packed {
    logic [4:0]   s1;
    logic [4:0]   s2;
    logic [4:0]   s3;
    logic [4:0]   filt;
    logic         link_prev;
    logic         pos_q;
    logic         neg_q;
    logic [1:0]   gear_a;
    logic         phase;
    logic [11:0]  ctrl;
    logic         overrun;
    logic [31:0]  rdata;
    logic         push;
    logic [3:0]   push_data;
    logic         out_valid;
    logic [3:0]   out_data;
    logic         byp_comb;
    logic         byp_clk;
  } digc_st_t;

  digc_st_t   st;
  digc_st_t   next_st;
  digc_mode_t mode;
  logic       link_f;
  logic       rise;
  logic       fall;
  logic       xfer;
  logic       data_in;
  logic       dly_q;
  logic [3:0] dly_sel;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [3:0] fifo_out_data;
  logic [3:0] fifo_count;

  function automatic logic edge_of(input logic now, input logic was, input logic up);
    edge_of = up ? (now && !was) : (!now && was);
  endfunction : edge_of

  always_comb begin
    mode = digc_mode_t'(st.ctrl[`DIGC_CTRL_MODE_HI:`DIGC_CTRL_MODE_LO]);
    link_f = st.ctrl[`DIGC_CTRL_MEM_MODE] ? st.filt[`DIGC_SY_STROBE] : st.filt[`DIGC_SY_EDGE];
    rise = edge_of(link_f, st.link_prev, 1'b1);
    fall = edge_of(link_f, st.link_prev, 1'b0);
    xfer = st.filt[`DIGC_SY_POL] ? fall : rise;
    if (st.ctrl[`DIGC_CTRL_DELAY_DYN]) begin
      dly_sel = DYNAMIC_DELAY_SELECT;
    end else begin
      dly_sel = st.ctrl[`DIGC_CTRL_FIXED_HI:`DIGC_CTRL_FIXED_LO];
    end
    data_in = st.ctrl[`DIGC_CTRL_DELAY_EN] ? dly_q : st.filt[`DIGC_SY_PAD];
    fifo_pop = !st.out_valid || OUT_READY;
  end

  always_comb begin
    next_st = st;
    next_st.s1 = {SYNC_TRANSFER_LATCH, SYNC_CLOCK_POLARITY, EDGE_CLOCK, SHIFTED_STROBE_CLOCK, PAD_INPUT_DATA};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 5; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    next_st.link_prev = link_f;
    next_st.byp_comb = st.filt[`DIGC_SY_PAD];
    next_st.byp_clk = st.filt[`DIGC_SY_PAD];
    next_st.push = 1'b0;
    next_st.push_data = st.push_data;
    if (rise) begin
      next_st.pos_q = data_in;
    end
    if (fall) begin
      next_st.neg_q = data_in;
    end
    case (mode)
      DIGC_SDR: begin
        next_st.push = 1'b1;
        next_st.push_data = {3'h0, data_in};
        next_st.phase = 1'b0;
      end
      DIGC_DDR: begin
        next_st.phase = 1'b0;
        if (xfer && st.filt[`DIGC_SY_LAT]) begin
          next_st.push = 1'b1;
          next_st.push_data = {2'h0, st.neg_q, st.pos_q};
        end
      end
      DIGC_GEAR: begin
        if (SIDE_LR && xfer && st.filt[`DIGC_SY_LAT]) begin
          if (!st.phase) begin
            next_st.gear_a = {st.neg_q, st.pos_q};
            next_st.phase = 1'b1;
          end else begin
            next_st.push = 1'b1;
            next_st.push_data = {st.neg_q, st.pos_q, st.gear_a};
            next_st.phase = 1'b0;
          end
        end
      end
      default: begin
        next_st.phase = 1'b0;
      end
    endcase
    if (fifo_pop) begin
      next_st.out_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        next_st.out_data = fifo_out_data;
      end
    end
    next_st.rdata = 32'h0;
    if (WR && ADDR == `DIGC_ADDR_CTRL) begin
      next_st.ctrl = WDATA[11:0];
      next_st.phase = 1'b0;
    end
    if (WR && ADDR == `DIGC_ADDR_STATUS && WDATA[`DIGC_STAT_OVERRUN]) begin
      next_st.overrun = 1'b0;
    end
    if (st.push && !fifo_in_ready) begin
      next_st.overrun = 1'b1;
    end
    if (RD) begin
      case (ADDR)
        `DIGC_ADDR_CTRL: begin
          next_st.rdata = {20'h0, st.ctrl};
        end
        `DIGC_ADDR_STATUS: begin
          next_st.rdata[`DIGC_STAT_COUNT_HI:`DIGC_STAT_COUNT_LO] = fifo_count;
          next_st.rdata[`DIGC_STAT_OVERRUN] = st.overrun;
          next_st.rdata[`DIGC_STAT_LINK] = link_f;
          next_st.rdata[`DIGC_STAT_PHASE] = st.phase;
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.ctrl <= `DIGC_CTRL_RESET;
      st.s1 <= `DIGC_SY_RESET;
      st.s2 <= `DIGC_SY_RESET;
      st.s3 <= `DIGC_SY_RESET;
      st.filt <= `DIGC_SY_RESET;
    end else begin
      st <= next_st;
    end
  end

  digc_delay u_delay (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (st.filt[`DIGC_SY_PAD]),
    .sel    (dly_sel),
    .q      (dly_q)
  );

  digc_fifo #(
    .W (`DIGC_WORD_W),
    .D (`DIGC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .resetn    (RESETN),
    .in_valid  (st.push),
    .in_ready  (fifo_in_ready),
    .in_data   (st.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  assign RDATA = st.rdata;
  assign BYPASS_COMB_INPUT = st.byp_comb;
  assign BYPASS_CLOCK_INPUT = st.byp_clk;
  assign OUT_VALID = st.out_valid;
  assign GEARBOX_POS_STREAM_A = st.out_data[0];
  assign GEARBOX_NEG_STREAM_A = st.out_data[1];
  assign GEARBOX_POS_STREAM_B = st.out_data[2];
  assign GEARBOX_NEG_STREAM_B = st.out_data[3];

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_bypass_path: assert property (##1 BYPASS_COMB_INPUT == $past(st.filt[`DIGC_SY_PAD])
    && BYPASS_CLOCK_INPUT == BYPASS_COMB_INPUT) else $error("bypass path wrong");
  a_sdr_capture: assert property ((mode == DIGC_SDR && !(WR && ADDR == `DIGC_ADDR_CTRL))
    |=> st.push && st.push_data == {3'h0, $past(data_in)}) else $error("sdr capture wrong");
  a_ddr_rise_fall: assert property ((rise |=> st.pos_q == $past(data_in))
    and (fall |=> st.neg_q == $past(data_in))) else $error("ddr edge capture wrong");
  a_ddr_transfer: assert property ((mode == DIGC_DDR && xfer && st.filt[`DIGC_SY_LAT]
    && !(WR && ADDR == `DIGC_ADDR_CTRL)) |=> st.push && st.push_data[1:0] == {$past(st.neg_q), $past(st.pos_q)})
    else $error("ddr transfer wrong");
  a_latch_gate: assert property ((mode != DIGC_SDR && !st.filt[`DIGC_SY_LAT]) |=> !st.push)
    else $error("push without transfer latch");
  a_pol_edge: assert property ((mode == DIGC_DDR && st.filt[`DIGC_SY_POL] && rise && !fall) |=> !st.push)
    else $error("transfer on wrong edge");
  a_gear_four: assert property ((mode == DIGC_GEAR && st.push && $past(mode) == DIGC_GEAR)
    |-> !st.phase && $past(st.phase)) else $error("gearbox words not paired");
  a_gear_phase: assert property ((SIDE_LR && mode == DIGC_GEAR && xfer && st.filt[`DIGC_SY_LAT]
    && !st.phase && !(WR && ADDR == `DIGC_ADDR_CTRL)) |=> st.phase && !st.push)
    else $error("gearbox first pair not held");
  a_mode_off: assert property ((mode == DIGC_OFF) |=> !st.push) else $error("push while capture off");
  a_out_hold: assert property ((OUT_VALID && !OUT_READY) |=> OUT_VALID && $stable(st.out_data))
    else $error("stream word changed before taken");
  a_gear_order: assert property ((mode == DIGC_GEAR && st.push && $past(mode) == DIGC_GEAR)
    |-> st.push_data[1:0] == $past(st.gear_a)) else $error("gearbox stream a wrong");
  a_sync_filter: assert property (($past(st.s2[`DIGC_SY_PAD]) != $past(st.s3[`DIGC_SY_PAD]))
    |-> $stable(st.filt[`DIGC_SY_PAD])) else $error("sync filter let a glitch through");
  a_read_once: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside its cycle");
  a_overrun_set: assert property ((st.push && !fifo_in_ready) |=> st.overrun) else $error("overrun not flagged");

  c_sdr_word: cover property (mode == DIGC_SDR ##1 OUT_VALID);
  c_ddr_word: cover property (mode == DIGC_DDR && st.push);
  c_gear_word: cover property (mode == DIGC_GEAR && st.push ##[1:20] OUT_VALID);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule : digc_capture

//--- digc_defs.svh
// offsets, field positions, reset values and sync indices of the input capture block
`ifndef DIGC_DEFS_SVH
`define DIGC_DEFS_SVH
`define DIGC_ADDR_CTRL       8'h00
`define DIGC_ADDR_STATUS     8'h04
`define DIGC_CTRL_RESET      12'h000
`define DIGC_CTRL_MODE_LO    0
`define DIGC_CTRL_MODE_HI    1
`define DIGC_CTRL_MEM_MODE   2
`define DIGC_CTRL_DELAY_EN   3
`define DIGC_CTRL_DELAY_DYN  4
`define DIGC_CTRL_FIXED_LO   8
`define DIGC_CTRL_FIXED_HI   11
`define DIGC_STAT_COUNT_LO   0
`define DIGC_STAT_COUNT_HI   3
`define DIGC_STAT_OVERRUN    8
`define DIGC_STAT_LINK       16
`define DIGC_STAT_PHASE      17
`define DIGC_SY_PAD          0
`define DIGC_SY_STROBE       1
`define DIGC_SY_EDGE         2
`define DIGC_SY_POL          3
`define DIGC_SY_LAT          4
`define DIGC_SY_RESET        5'h00
`define DIGC_FIFO_DEPTH      8
`define DIGC_WORD_W          4
`define DIGC_DELAY_TAPS      16
`endif

//--- digc_pkg.sv
// types of the input capture block
package digc_pkg;
  typedef enum logic [1:0] {DIGC_SDR, DIGC_DDR, DIGC_GEAR, DIGC_OFF} digc_mode_t;
endpackage : digc_pkg

//--- digc_delay.sv
// tapped input delay line with registered output
`include "digc_defs.svh"
module digc_delay
  import digc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       d,
  input  wire logic [3:0] sel,
  output logic            q
);
  typedef struct packed {
    logic [`DIGC_DELAY_TAPS-1:0] sh;
    logic                        q;
  } digc_dly_st_t;
  digc_dly_st_t st;
  digc_dly_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[`DIGC_DELAY_TAPS-2:0], d};
    if (sel == 4'h0) begin
      next_st.q = d;
    end else begin
      next_st.q = st.sh[4'(sel - 4'h1)];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  a_delay_zero: assert property (@(posedge clk) disable iff (!resetn)
    (sel == 4'h0) |=> (q == $past(d))) else $error("zero delay tap wrong");
  a_delay_tap: assert property (@(posedge clk) disable iff (!resetn)
    (sel == 4'h3) ##1 (sel == 4'h3) |-> (q == $past(d, 4))) else $error("delay tap three wrong");
endmodule : digc_delay

//--- digc_fifo.sv
// small fifo with registered read data, valid and ready on both sides
module digc_fifo
  import digc_pkg::*;
#(
  parameter int W = 4,
  parameter int D = 8
)(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D+1)-1:0]    count
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0]     mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [$clog2(D+1)-1:0]  cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } digc_fifo_st_t;
  digc_fifo_st_t st;
  digc_fifo_st_t next_st;
  logic push;
  logic pop;

  always_comb begin
    next_st = st;
    push = in_valid && (st.cnt != ($clog2(D+1))'(D));
    pop = (st.cnt != '0) && (!st.ov || out_ready);
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = AW'(st.wp + 1'b1);
    end
    if (pop) begin
      next_st.od = st.mem[st.rp];
      next_st.rp = AW'(st.rp + 1'b1);
      next_st.ov = 1'b1;
    end else if (out_ready) begin
      next_st.ov = 1'b0;
    end
    next_st.cnt = st.cnt + (($clog2(D+1))'(push)) - (($clog2(D+1))'(pop));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = (st.cnt != ($clog2(D+1))'(D));
  assign out_valid = st.ov;
  assign out_data = st.od;
  assign count = st.cnt;
endmodule : digc_fifo

//--- digc_link_src.sv
// source-synchronous transmitter model: pad data plus a strobe or edge clock
module digc_link_src (
  input  wire logic strobe_sel,
  output logic      strobe_clk,
  output logic      edge_clk,
  output logic      data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  initial begin
    busy = 1'b0;
    data = 1'b0;
    strobe_clk = 1'b0;
    edge_clk = 1'b0;
  end
  // a released line keeps changing, so no stale level can pass for data
  always #8 if (!busy) data = ~data;
  task automatic set_clk(input logic v);
    if (strobe_sel) strobe_clk = v;
    else edge_clk = v;
  endtask : set_clk
  task automatic hold(input logic v);
    busy = 1'b1;
    data = v;
  endtask : hold
  // clock stands still outside a frame; data changes 20 ns before each edge
  task automatic send(input logic p, input logic n, input int cyc);
    busy = 1'b1;
    for (int i = 0; i < cyc; i++) begin
      data = p;
      #20;
      set_clk(1'b1);
      #20;
      data = n;
      #20;
      set_clk(1'b0);
      #20;
    end
    busy = 1'b0;
  endtask : send
endmodule : digc_link_src

//--- tb.sv
// testbench of the input capture block with a link source model
`include "digc_defs.svh"
module tb
  import digc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESETN, WR, RD, OUT_READY, OUT_VALID, BYPASS_COMB_INPUT, BYPASS_CLOCK_INPUT;
  logic        GEARBOX_POS_STREAM_A, GEARBOX_NEG_STREAM_A, GEARBOX_POS_STREAM_B, GEARBOX_NEG_STREAM_B;
  logic        SYNC_CLOCK_POLARITY, SYNC_TRANSFER_LATCH, pad, sclk, edge_clock, sel;
  logic        rdy_rand, rdy_fix, chk_on, rd_pend, v, p;
  logic [3:0]  DYNAMIC_DELAY_SELECT;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, exp_word;
  logic [63:0] rq[$];
  digc_mode_t  m;
  int          num_errors, n_compared, nwords, base, cyc, cnt;

  digc_capture u_digc_capture (
    .CLK                  (CLK),
    .RESETN               (RESETN),
    .ADDR                 (ADDR),
    .WDATA                (WDATA),
    .WR                   (WR),
    .RD                   (RD),
    .RDATA                (RDATA),
    .PAD_INPUT_DATA       (pad),
    .SHIFTED_STROBE_CLOCK (sclk),
    .EDGE_CLOCK           (edge_clock),
    .SYNC_CLOCK_POLARITY  (SYNC_CLOCK_POLARITY),
    .SYNC_TRANSFER_LATCH  (SYNC_TRANSFER_LATCH),
    .DYNAMIC_DELAY_SELECT (DYNAMIC_DELAY_SELECT),
    .OUT_READY            (OUT_READY),
    .BYPASS_COMB_INPUT    (BYPASS_COMB_INPUT),
    .BYPASS_CLOCK_INPUT   (BYPASS_CLOCK_INPUT),
    .OUT_VALID            (OUT_VALID),
    .GEARBOX_POS_STREAM_A (GEARBOX_POS_STREAM_A),
    .GEARBOX_NEG_STREAM_A (GEARBOX_NEG_STREAM_A),
    .GEARBOX_POS_STREAM_B (GEARBOX_POS_STREAM_B),
    .GEARBOX_NEG_STREAM_B (GEARBOX_NEG_STREAM_B)
  );
  digc_link_src u_digc_link_src (
    .strobe_sel (sel),
    .strobe_clk (sclk),
    .edge_clk   (edge_clock),
    .data       (pad)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    rq.push_back({mk, e & mk});
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
  endtask : rd

  initial forever #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  always @(posedge CLK) OUT_READY <= rdy_rand ? 1'($urandom) : rdy_fix;
  // read data stand only in the cycle after the strobe; stream words when taken while chk_on, skipping the first two
  always @(posedge CLK) begin
    if (rd_pend) begin
      check(RDATA & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    rd_pend <= RD;
    if (OUT_VALID && OUT_READY) begin
      nwords <= nwords + 1;
      if (chk_on && nwords - base >= 2) check({28'h0, GEARBOX_NEG_STREAM_B, GEARBOX_POS_STREAM_B,
        GEARBOX_NEG_STREAM_A, GEARBOX_POS_STREAM_A}, exp_word);
    end
  end

  initial begin
    CLK = 1'b0;
    RESETN = 1'b0;
    {WR, RD, rdy_rand, chk_on, rd_pend, sel, SYNC_CLOCK_POLARITY} = '0;
    {rdy_fix, SYNC_TRANSFER_LATCH} = 2'h3;
    ADDR = 8'h00;
    WDATA = 32'h0;
    DYNAMIC_DELAY_SELECT = 4'h0;
    OUT_READY = 1'b1;
    exp_word = 32'h0;
    {num_errors, n_compared, nwords, base, cyc} = '0;
    void'($urandom(60864));
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    rd(`DIGC_ADDR_CTRL, 32'h0, 32'hffffffff);
    rd(8'h08, 32'h0, 32'hffffffff);
    wr(`DIGC_ADDR_CTRL, 32'h00000f1d);
    rd(`DIGC_ADDR_CTRL, 32'h00000f1d, 32'h00000fff);
    wr(`DIGC_ADDR_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      v = 1'($urandom);
      u_digc_link_src.hold(v);
      repeat (8) @(posedge CLK);
      check(32'(BYPASS_COMB_INPUT), 32'(v));
      check(32'(BYPASS_CLOCK_INPUT), 32'(v));
    end
    // sdr with fixed then dynamic delay, random core stalls
    for (int k = 0; k < 2; k++) begin
      v = 1'($urandom);
      u_digc_link_src.hold(v);
      DYNAMIC_DELAY_SELECT <= 4'($urandom);
      exp_word <= 32'(v);
      repeat (40) @(posedge CLK);
      wr(`DIGC_ADDR_CTRL, {20'h0, 4'($urandom), 3'h0, k[0], 1'b1, 1'b0, DIGC_SDR});
      base <= nwords;
      chk_on <= 1'b1;
      rdy_rand <= 1'b1;
      repeat (60) @(posedge CLK);
      chk_on <= 1'b0;
      wr(`DIGC_ADDR_CTRL, 32'h3);
      rdy_rand <= 1'b0;
      repeat (30) @(posedge CLK);
    end
    // fill the buffer with the core stalled, then clear overrun and drain
    rdy_fix <= 1'b0;
    wr(`DIGC_ADDR_CTRL, 32'h0);
    repeat (30) @(posedge CLK);
    wr(`DIGC_ADDR_CTRL, 32'h3);
    repeat (10) @(posedge CLK);
    rd(`DIGC_ADDR_STATUS, 32'h108, 32'h10f);
    wr(`DIGC_ADDR_STATUS, 32'h100);
    rd(`DIGC_ADDR_STATUS, 32'h008, 32'h10f);
    rdy_fix <= 1'b1;
    repeat (30) @(posedge CLK);
    rd(`DIGC_ADDR_STATUS, 32'h0, 32'h10f);
    // link frames: ddr and gearbox at both polarities and clocks, then latch low
    for (int i = 0; i < 5; i++) begin
      m = (i == 2 || i == 3) ? DIGC_GEAR : DIGC_DDR;
      p = 1'($urandom);
      SYNC_CLOCK_POLARITY <= i[0];
      SYNC_TRANSFER_LATCH <= (i != 4);
      sel <= i[0];
      exp_word <= (m == DIGC_GEAR) ? {28'h0, ~p, p, ~p, p} : {30'h0, ~p, p};
      wr(`DIGC_ADDR_CTRL, {29'h0, i[0], m});
      repeat (10) @(posedge CLK);
      base <= nwords;
      chk_on <= 1'b1;
      rdy_rand <= 1'b1;
      @(posedge CLK);
      u_digc_link_src.send(p, ~p, 24);
      repeat (60) @(posedge CLK);
      rdy_rand <= 1'b0;
      chk_on <= 1'b0;
      repeat (20) @(posedge CLK);
      cnt = nwords - base;
      if (i == 4) check(32'(cnt), 32'h0);
      else if (m == DIGC_GEAR) check(32'(cnt >= 10 && cnt <= 13), 32'h1);
      else check(32'(cnt >= 22 && cnt <= 25), 32'h1);
    end
    give_verdict();
  end
endmodule : tb
